// file: i2c_mode_clock_pkg.sv
package i2c_mode_clock_pkg;
  // Register index map on the plain register port
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h1;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h2;
  localparam logic [2:0] ADDR_OWN_ADDR = 3'h3;
  localparam logic [2:0] ADDR_RX_BUF = 3'h4;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h00;

  // Interrupt status bit positions
  localparam int IRQ_ARB_LOST = 0;
  localparam int IRQ_ADDR_MATCH = 1;
  localparam int IRQ_OVERRUN = 2;

  // Slave transmit data set-up time, in phi cycles
  localparam logic [4:0] SETUP_SHORT_CYC = 5'h0a;
  localparam logic [4:0] SETUP_LONG_CYC = 5'h14;

  // Serial clock divisors, indexed by the divider code
  localparam logic [8:0] DIV_TABLE [16] = '{
    9'h01c, 9'h028, 9'h030, 9'h040, 9'h050, 9'h064, 9'h070, 9'h080,
    9'h038, 9'h050, 9'h060, 9'h080, 9'h0a0, 9'h0c8, 9'h0e0, 9'h100
  };

  // First control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic interface_enable_bit;
    logic next_reception_inhibit;
    logic master_select_bit;
    logic transmit_select_bit;
    logic [3:0] clock_divider_field;
  } bus_control_mode_clock_t;

  // Operating mode, master select over transmit select
  typedef enum logic [1:0] {
    MODE_SLAVE_RX = 2'b00,
    MODE_SLAVE_TX = 2'b01,
    MODE_MASTER_RX = 2'b10,
    MODE_MASTER_TX = 2'b11
  } op_mode_t;

  // Set-up timer states
  typedef enum logic [1:0] {
    SU_IDLE = 2'b01,
    SU_COUNT = 2'b10
  } setup_state_t;

  // Open-drain pin pair
  typedef struct packed {
    logic out;
    logic oe_b;
  } pin_drive_t;
endpackage

// file: i2c_mode_and_clock_control.sv
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
module i2c_mode_and_clock_control
  import i2c_mode_clock_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // Datapath and sequencer
  input wire logic i_fmt_sync,
  input wire logic i_frame_active,
  input wire logic i_arb_lost,
  input wire logic i_overrun,
  input wire logic i_first_byte_valid,
  input wire logic [7:0] i_first_byte,
  input wire logic [7:0] i_rx_buf_data,
  input wire logic i_setup_start,
  input wire logic i_sda_drive_low,
  output logic o_enable,
  output i2c_mode_clock_pkg::op_mode_t o_mode,
  output logic o_next_rx_start,
  output logic o_setup_done,
  output logic o_scl_tick,
  output logic o_scl_level,
  output logic o_sda_level,
  // Serial pins
  input wire logic i_scl,
  input wire logic i_sda,
  output i2c_mode_clock_pkg::pin_drive_t o_scl,
  output i2c_mode_clock_pkg::pin_drive_t o_sda,
  output logic o_pins_port_fn,
  // Interrupt
  output logic o_irq
);
  import i2c_mode_clock_pkg::*;

  bus_control_mode_clock_t ctrl_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [6:0] own_addr_reg;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [8:0] div_cnt_reg;
  logic scl_phase_reg;
  logic [4:0] setup_cnt_reg;
  setup_state_t setup_state_reg;
  logic next_rx_reg;
  logic setup_done_reg;
  logic tick_reg;
  logic [7:0] rd_data_reg;

  logic arb_event;
  logic match_event;
  logic overrun_event;
  logic [2:0] irq_events;
  logic [8:0] half_div;
  logic scl_stretched;
  logic clk_out_en;

  // Event qualification, all gated by the enable
  assign arb_event = ctrl_reg.interface_enable_bit && ctrl_reg.master_select_bit &&
                     !i_fmt_sync && i_arb_lost;
  assign match_event = ctrl_reg.interface_enable_bit && !ctrl_reg.master_select_bit &&
                       !ctrl_reg.transmit_select_bit && i_first_byte_valid &&
                       (i_first_byte[7:1] == own_addr_reg) && i_first_byte[0];
  assign overrun_event = ctrl_reg.interface_enable_bit && ctrl_reg.master_select_bit &&
                         i_fmt_sync && i_overrun;
  assign irq_events = {overrun_event, match_event, arb_event};

  // Control register; hardware mode changes win over a same-cycle write
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (i_wr && (i_addr == ADDR_CTRL)) begin
        ctrl_reg <= i_wr_data;
      end
      if (arb_event) begin
        ctrl_reg.master_select_bit <= 1'b0;
        ctrl_reg.transmit_select_bit <= 1'b0;
      end else if (overrun_event) begin
        ctrl_reg.master_select_bit <= 1'b0;
      end
      if (match_event) begin
        ctrl_reg.transmit_select_bit <= 1'b1;
      end
    end
  end

  // Own address and interrupt mask
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      own_addr_reg <= OWN_ADDR_RESET;
      irq_mask_reg <= IRQ_RESET;
    end else begin
      if (i_wr && (i_addr == ADDR_OWN_ADDR)) begin
        own_addr_reg <= i_wr_data[6:0];
      end
      if (i_wr && (i_addr == ADDR_IRQ_MASK)) begin
        irq_mask_reg <= i_wr_data[2:0];
      end
    end
  end

  // Sticky status; a new event beats a write-one clear
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_status_reg <= IRQ_RESET;
    end else if (i_wr && (i_addr == ADDR_IRQ_STATUS)) begin
      irq_status_reg <= (irq_status_reg & ~i_wr_data[2:0]) | irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  assign o_irq = |(irq_status_reg & irq_mask_reg);

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_data_reg <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_CTRL: rd_data_reg <= ctrl_reg;
        ADDR_IRQ_STATUS: rd_data_reg <= {5'h00, irq_status_reg};
        ADDR_IRQ_MASK: rd_data_reg <= {5'h00, irq_mask_reg};
        ADDR_OWN_ADDR: rd_data_reg <= {1'b0, own_addr_reg};
        ADDR_RX_BUF: rd_data_reg <= i_rx_buf_data;
        default: rd_data_reg <= 8'h00;
      endcase
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  assign o_rd_data = rd_data_reg;

  // Next reception request on a buffer read in receive direction
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      next_rx_reg <= 1'b0;
    end else begin
      next_rx_reg <= i_rd && (i_addr == ADDR_RX_BUF) && ctrl_reg.interface_enable_bit &&
                     !ctrl_reg.transmit_select_bit && !ctrl_reg.next_reception_inhibit;
    end
  end

  assign o_next_rx_start = next_rx_reg;

  // Pin synchronisers; only the second stage is looked at
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
    end
  end

  assign o_scl_level = scl_sync_reg[1];
  assign o_sda_level = sda_sync_reg[1];

  // Clock generation runs only as master inside a frame
  assign clk_out_en = ctrl_reg.interface_enable_bit && ctrl_reg.master_select_bit && i_frame_active;
  assign half_div = {1'b0, DIV_TABLE[ctrl_reg.clock_divider_field][8:1]};
  // Another master holding SCL low stretches our high phase (I2C only)
  assign scl_stretched = !i_fmt_sync && scl_phase_reg && !scl_sync_reg[1];

  // Serial clock divider, half period per phase
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_cnt_reg <= 9'h000;
      scl_phase_reg <= 1'b1;
      tick_reg <= 1'b0;
    end else if (!clk_out_en) begin
      div_cnt_reg <= 9'h000;
      scl_phase_reg <= 1'b1;
      tick_reg <= 1'b0;
    end else if (scl_stretched) begin
      tick_reg <= 1'b0;
    end else if (div_cnt_reg >= half_div - 9'h001) begin // Catches a count left above a smaller new divisor
      div_cnt_reg <= 9'h000;
      scl_phase_reg <= !scl_phase_reg;
      tick_reg <= !scl_phase_reg; // Pulse on each rising phase
    end else begin
      div_cnt_reg <= div_cnt_reg + 9'h001;
      tick_reg <= 1'b0;
    end
  end

  assign o_scl_tick = tick_reg;

  // Slave transmit set-up timer
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      setup_state_reg <= SU_IDLE;
      setup_cnt_reg <= 5'h00;
      setup_done_reg <= 1'b0;
    end else if (!ctrl_reg.interface_enable_bit) begin
      setup_state_reg <= SU_IDLE;
      setup_cnt_reg <= 5'h00;
      setup_done_reg <= 1'b0;
    end else begin
      setup_done_reg <= 1'b0;
      case (setup_state_reg)
        SU_IDLE: begin
          if (i_setup_start && (o_mode == MODE_SLAVE_TX)) begin
            setup_state_reg <= SU_COUNT;
            setup_cnt_reg <= ctrl_reg.clock_divider_field[3] ? SETUP_LONG_CYC - 5'h01
                                                               : SETUP_SHORT_CYC - 5'h01;
          end
        end
        SU_COUNT: begin
          if (setup_cnt_reg == 5'h00) begin
            setup_state_reg <= SU_IDLE;
            setup_done_reg <= 1'b1;
          end else begin
            setup_cnt_reg <= setup_cnt_reg - 5'h01;
          end
        end
        default: begin
          setup_state_reg <= SU_IDLE;
        end
      endcase
    end
  end

  assign o_setup_done = setup_done_reg;

  // Mode decode and enable
  assign o_mode = op_mode_t'({ctrl_reg.master_select_bit, ctrl_reg.transmit_select_bit});
  assign o_enable = ctrl_reg.interface_enable_bit;
  assign o_pins_port_fn = !ctrl_reg.interface_enable_bit;

  // Pin drive: released when disabled; clocked sync master drives push-pull
  always_comb begin
    o_scl.out = 1'b0;
    o_scl.oe_b = 1'b1;
    o_sda.out = 1'b0;
    o_sda.oe_b = 1'b1;
    if (ctrl_reg.interface_enable_bit) begin
      if (i_fmt_sync && ctrl_reg.master_select_bit) begin
        o_scl.out = scl_phase_reg;
        o_scl.oe_b = 1'b0;
      end else if (!i_fmt_sync && clk_out_en && !scl_phase_reg) begin
        o_scl.oe_b = 1'b0; // Open drain: only pull low
      end
      if (i_sda_drive_low) begin
        o_sda.oe_b = 1'b0;
      end
    end
  end
endmodule

// file: i2c_mode_clock_monitor.sv
`timescale 1ns/10ps
module i2c_mode_clock_monitor
  import i2c_mode_clock_pkg::*;
(
  // Clock, reset and register port
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rd_data,
  // Sequencer side
  input wire logic i_fmt_sync,
  input wire logic i_arb_lost,
  input wire logic i_overrun,
  input wire logic i_setup_start,
  input wire logic o_enable,
  input i2c_mode_clock_pkg::op_mode_t o_mode,
  input wire logic o_next_rx_start,
  input wire logic o_setup_done,
  input wire logic o_scl_tick,
  // Pins
  input i2c_mode_clock_pkg::pin_drive_t o_scl,
  input i2c_mode_clock_pkg::pin_drive_t o_sda,
  input wire logic o_pins_port_fn
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // Pins belong to the port while disabled
  a_port_release: assert property (!o_enable |-> o_pins_port_fn && o_scl.oe_b && o_sda.oe_b)
    else $error("pins held while disabled");
  a_arb_lost_clear: assert property (o_enable && o_mode[1] && !i_fmt_sync && i_arb_lost |=> o_mode == MODE_SLAVE_RX)
    else $error("arbitration loss kept master");
  a_overrun_clear: assert property (o_enable && o_mode == MODE_MASTER_TX && i_fmt_sync && i_overrun && !i_arb_lost
    |=> o_mode == MODE_SLAVE_TX)
    else $error("overrun kept master");
  a_next_rx_cause: assert property (o_next_rx_start |-> $past(i_rd) && $past(i_addr) == ADDR_RX_BUF
    && $past(o_enable) && !$past(o_mode[0]))
    else $error("next reception without buffer read");
  // Done is registered, so the start sample sits 11 or 21 edges back
  a_setup_span: assert property (o_setup_done |-> $past(i_setup_start, 11) || $past(i_setup_start, 21))
    else $error("set-up span wrong");
  a_sync_clock_out: assert property (o_enable && o_mode[1] && i_fmt_sync |-> !o_scl.oe_b)
    else $error("clock not driven");
  // One cycle of grace after disable for registered pulses
  a_disabled_quiet: assert property (!o_enable && !$past(o_enable)
    |-> !o_scl_tick && !o_setup_done && !o_next_rx_start)
    else $error("activity while disabled");
  a_mode_readback: assert property ($past(i_rd) && $past(i_addr) == ADDR_CTRL
    |-> o_rd_data[5:4] == $past(o_mode) && o_rd_data[7] == $past(o_enable))
    else $error("mode readback wrong");
endmodule

// file: i2c_bus_partner.sv
`timescale 1ns/10ps
module i2c_bus_partner
  import i2c_mode_clock_pkg::*;
(
  // Drives of the block
  input i2c_mode_clock_pkg::pin_drive_t i_scl_drv,
  input i2c_mode_clock_pkg::pin_drive_t i_sda_drv,
  // Far node holding the clock low
  input wire logic i_stretch,
  // Resolved wire levels
  output logic o_scl,
  output logic o_sda
);
  // Pull-ups win unless driven; the far node can only pull low
  assign o_scl = (i_scl_drv.oe_b ? 1'b1 : i_scl_drv.out) & !i_stretch;
  assign o_sda = i_sda_drv.oe_b ? 1'b1 : i_sda_drv.out;
endmodule

// file: i2c_mode_and_clock_control_test.sv
`timescale 1ns/10ps
module i2c_mode_and_clock_control_test;
  import i2c_mode_clock_pkg::*;
  logic i_clk_sys = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_fmt_sync = 1'b0, i_frame_active = 1'b0;
  logic i_arb_lost = 1'b0, i_overrun = 1'b0, i_first_byte_valid = 1'b0, i_setup_start = 1'b0;
  logic i_sda_drive_low = 1'b0, i_stretch = 1'b0, i_scl, i_sda, o_enable, o_next_rx_start, o_setup_done;
  logic o_scl_tick, o_scl_level, o_sda_level, o_pins_port_fn, o_irq, i0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wr_data = 8'h00, i_first_byte = 8'h00, i_rx_buf_data = 8'h00, o_rd_data, d;
  op_mode_t o_mode;
  pin_drive_t o_scl, o_sda;
  int n_fail = 0, n_checks = 0, n;
  int div_tab [16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
  always #2 i_clk_sys = ~i_clk_sys;
  i2c_mode_and_clock_control i2c_mode_and_clock_control_inst (.i_clk_sys, .i_rst_b, .i_addr, .i_wr_data, .i_wr,
    .i_rd, .o_rd_data, .i_fmt_sync, .i_frame_active, .i_arb_lost, .i_overrun, .i_first_byte_valid, .i_first_byte,
    .i_rx_buf_data, .i_setup_start, .i_sda_drive_low, .o_enable, .o_mode, .o_next_rx_start, .o_setup_done,
    .o_scl_tick, .o_scl_level, .o_sda_level, .i_scl, .i_sda, .o_scl, .o_sda, .o_pins_port_fn, .o_irq);
  i2c_bus_partner i2c_bus_partner_inst (.i_scl_drv(o_scl), .i_sda_drv(o_sda), .i_stretch, .o_scl(i_scl), .o_sda(i_sda));
  // Bus cycles: one-cycle strobes, settle a step past the edge
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    {i_wr, i_addr, i_wr_data} <= {1'b1, a, v};
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [2:0] a);
    @(posedge i_clk_sys);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rd_data;
  endtask
  // One-cycle event pulse: 0 arb, 1 overrun, 2 first byte, 3 set-up
  task pulse(input int k);
    @(posedge i_clk_sys);
    {i_setup_start, i_first_byte_valid, i_overrun, i_arb_lost} <= 4'h1 << k;
    @(posedge i_clk_sys);
    {i_setup_start, i_first_byte_valid, i_overrun, i_arb_lost} <= 4'h0;
    #1;
  endtask
  // Bounded wait; 600 means no tick came
  task wait_tick();
    n = 0;
    do begin @(posedge i_clk_sys); #1; n++; end while (o_scl_tick !== 1'b1 && n < 600);
  endtask
  task t_regs();
    rd(ADDR_CTRL); `CHK("ctrl reset", 8'h00, d)
    `CHK("port fn", 1'b1, o_pins_port_fn)
    wr(3'h7, 8'hff); rd(3'h7); `CHK("unmapped", 8'h00, d)
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, {2'h2, m[1:0], 4'h0}); rd(ADDR_CTRL); `CHK("ctrl rd", {2'h2, m[1:0], 4'h0}, d)
      `CHK("mode", op_mode_t'(m), o_mode)
    end
    `CHK("bus fn", 1'b0, o_pins_port_fn)
    i_sda_drive_low <= 1'b1; repeat (4) @(posedge i_clk_sys); #1 `CHK("sda low", 1'b0, o_sda_level)
    `CHK("scl idle", 1'b1, o_scl_level)
    `CHK("enable", 1'b1, o_enable)
    i_sda_drive_low <= 1'b0;
    $display("t_regs done");
  endtask
  task t_next_rx();
    i_rx_buf_data <= 8'h5a;
    wr(ADDR_CTRL, 8'h80); rd(ADDR_RX_BUF); `CHK("rx buf", 8'h5a, d)
    `CHK("rx start", 1'b1, o_next_rx_start)
    wr(ADDR_CTRL, 8'hc0); rd(ADDR_RX_BUF); `CHK("rx inhibit", 1'b0, o_next_rx_start)
    wr(ADDR_CTRL, 8'h90); rd(ADDR_RX_BUF); `CHK("rx tx dir", 1'b0, o_next_rx_start)
    $display("t_next_rx done");
  endtask
  task t_events();
    wr(ADDR_IRQ_MASK, 8'h00); wr(ADDR_CTRL, 8'hb0); pulse(0); `CHK("arb mode", MODE_SLAVE_RX, o_mode)
    i0 = o_irq; wr(ADDR_IRQ_MASK, 8'h07); `CHK("irq mask", 1'b1, i0 ^ o_irq)
    rd(ADDR_IRQ_STATUS); `CHK("arb flag", 8'h01, d)
    wr(ADDR_IRQ_STATUS, 8'h07); rd(ADDR_IRQ_STATUS); `CHK("w1c", 8'h00, d)
    i_fmt_sync <= 1'b1; wr(ADDR_CTRL, 8'hb0); `CHK("clk out", 1'b0, o_scl.oe_b)
    pulse(1); `CHK("ovr mode", MODE_SLAVE_TX, o_mode)
    i_fmt_sync <= 1'b0; wr(ADDR_OWN_ADDR, 8'h2a); wr(ADDR_CTRL, 8'h80);
    i_first_byte <= 8'h57; pulse(2); `CHK("addr miss", MODE_SLAVE_RX, o_mode)
    i_first_byte <= 8'h54; pulse(2); `CHK("bit0 low", MODE_SLAVE_RX, o_mode)
    i_first_byte <= 8'h55; pulse(2); `CHK("addr hit", MODE_SLAVE_TX, o_mode)
    $display("t_events done");
  endtask
  task t_setup();
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL, {4'h9, k ? 4'h8 : 4'h0}); pulse(3); n = 0;
      while (o_setup_done !== 1'b1 && n < 40) begin @(posedge i_clk_sys); #1; n++; end
      `CHK("setup", k ? 20 : 10, n)
    end
    $display("t_setup done");
  endtask
  task t_divider();
    {i_fmt_sync, i_frame_active} <= 2'h3;
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_CTRL, {4'ha, c[3:0]}); wait_tick(); wait_tick(); wait_tick(); `CHK("divisor", div_tab[c], n)
    end
    // A far node holding SCL low must lengthen the period
    i_fmt_sync <= 1'b0; wr(ADDR_CTRL, 8'ha0); wait_tick(); n = 0;
    do begin @(posedge i_clk_sys); #1; n++; i_stretch <= (n < 40); end while (o_scl_tick !== 1'b1 && n < 600);
    `CHK("stretch", 1'b1, n > 40)
    $display("t_divider done");
  endtask
  task t_disabled();
    wr(ADDR_CTRL, 8'h2f); wr(ADDR_IRQ_STATUS, 8'h07); pulse(0); wait_tick(); `CHK("tick off", 600, n)
    `CHK("no arb", MODE_MASTER_RX, o_mode)
    rd(ADDR_IRQ_STATUS); `CHK("no flag", 8'h00, d)
    i_rst_b <= 1'b0; repeat (3) @(posedge i_clk_sys); i_rst_b <= 1'b1; rd(ADDR_CTRL); `CHK("rst again", 8'h00, d)
    $display("t_disabled done");
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_regs(); t_next_rx(); t_events(); t_setup(); t_divider(); t_disabled();
    wrap_up();
  end
  // Roughly eight times the expected run
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule
bind i2c_mode_and_clock_control i2c_mode_clock_monitor i2c_mode_clock_monitor_inst (.i_clk_sys, .i_rst_b, .i_addr,
  .i_rd, .o_rd_data, .i_fmt_sync, .i_arb_lost, .i_overrun, .i_setup_start, .o_enable, .o_mode, .o_next_rx_start,
  .o_setup_done, .o_scl_tick, .o_scl, .o_sda, .o_pins_port_fn);
